// *** core/rfid_modem_pkg.sv ***
// Purpose: Shared constants for the tag bit modem.
// Assumes: All link timing counted in coil carrier cycles at 125 kHz.
// Notes:   Times kept in their own units; cycle counts derived from them.
package rfid_modem_pkg;

	localparam int CARRIER_NS = 8000;

	localparam int OUT_BIT_US = 128;
	localparam int IN_BIT_US = 512;
	localparam int LEAD_MIN_US = 256;
	localparam int LEAD_MAX_US = 1024;
	localparam int RETX_US = 1664;
	localparam int OFF_MIN_US = 32;
	localparam int OFF_MAX_US = 368;
	localparam int SPACE_MIN_US = 400;
	localparam int SPACE_MAX_US = 624;
	localparam int MEM_PAUSE_US = 5900;
	localparam int TAMPER_PAUSE_US = 7900;

	localparam int CNT_W = 10;
	typedef logic [CNT_W-1:0] cnt_t;

	// Least times round up, longest times round down
	localparam cnt_t OUT_BIT_CYC = cnt_t'(OUT_BIT_US * 1000 / CARRIER_NS);
	localparam cnt_t OUT_HALF_CYC = cnt_t'(OUT_BIT_US * 500 / CARRIER_NS);
	localparam cnt_t IN_BIT_CYC = cnt_t'(IN_BIT_US * 1000 / CARRIER_NS);
	localparam cnt_t LEAD_MIN_CYC =
		cnt_t'((LEAD_MIN_US * 1000 + CARRIER_NS - 1) / CARRIER_NS);
	localparam cnt_t LEAD_MAX_CYC = cnt_t'(LEAD_MAX_US * 1000 / CARRIER_NS);
	localparam cnt_t RETX_CYC = cnt_t'(RETX_US * 1000 / CARRIER_NS);
	localparam cnt_t OFF_MIN_CYC =
		cnt_t'((OFF_MIN_US * 1000 + CARRIER_NS - 1) / CARRIER_NS);
	localparam cnt_t OFF_MAX_CYC = cnt_t'(OFF_MAX_US * 1000 / CARRIER_NS);
	localparam cnt_t TRACK_TOL_CYC =
		cnt_t'((SPACE_MAX_US - SPACE_MIN_US) * 500 / CARRIER_NS);
	localparam cnt_t MEM_PAUSE_CYC =
		cnt_t'((MEM_PAUSE_US * 1000 + CARRIER_NS - 1) / CARRIER_NS);
	localparam cnt_t TAMPER_PAUSE_CYC =
		cnt_t'((TAMPER_PAUSE_US * 1000 + CARRIER_NS - 1) / CARRIER_NS);

	localparam logic [1:0] LEADIN_BITS = 2'h3;
	localparam logic [1:0] LEADIN_GAP_BIT = 2'h1;

	// Transmit word: header flag, last flag, data byte
	localparam int WORD_W = 10;
	localparam int W_HDR = 9;
	localparam int W_LAST = 8;
	localparam int BYTE_MSB = 7;
	localparam int HDR_MSB = 3;
	localparam logic [2:0] DATA_IDX_FIRST = 3'h6;
	localparam logic [2:0] HDR_IDX_FIRST = 3'h1;

	localparam int BUF_DEPTH = 2;
	localparam int REPLAY_DEPTH = 16;
	localparam int REPLAY_AW = 4;

	typedef enum {M_IDLE, M_TX, M_LISTEN, M_RX, M_PAUSE} mode_e;
	typedef enum {G_DATA, G_PAR, G_STOP, G_HDR, G_END} gen_e;

endpackage

// *** core/rfid_tag_bit_modem.sv ***
// Purpose: Bit-level transmit and receive path of a field-powered tag.
// Assumes: Carrier, demodulator and supply flags are asynchronous pins.
// Notes:   All bit timing counts carrier edges, never clk cycles.
// Behaviour
// - Modulation resistor on while encoder output is 1, off while 0.
// - Miller code: 1 toggles mid-bit; 0 before 0 toggles at bit end.
// - Each non-header group opens with start bit 1, off-to-on mid-bit.
// - One transmit bit enters the encoder every 16 carrier cycles.
// - Each non-header group closes with one stop bit of value 0.
// - Amplitude drop reads low, rise high; invert before Manchester decoding.
// - Mid-bit high-to-low decodes 0, low-to-high decodes 1.
// - One received bit is decoded every 64 carrier cycles.
// - Receive bit clock starts on first lead-in change, times later edges.
// - Lead-in edges mid bit one and three set the tracked mid-bit position.
// - Bit-boundary transitions are ignored; only mid-bit transitions decode.
// - No lead-in edge within the window after a read: retransmit last data.
// - Memory commands abort when supply is below memory-access threshold.
// - Header, identifier, tamper and silence commands run at low supply.
// - Loss of wired supply briefly resets the radio logic.
// - Wired supply in its middle band inhibits memory read and write.
// - Outbound bit time nominally 128 us, scaling with carrier.
// - Inbound bit time nominally 512 us, scaling with carrier.
// - Write pause before response: 5.9 ms memory, 7.9 ms tamper.
// - Parity after every 8 data bits gives even ones in 9 bits.
// - Start of first and all of second inbound bit time ignored.
`timescale 1ns/1ps
module rfid_tag_bit_modem (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       coil_carrier,
	input  wire logic       demod_level,
	input  wire logic       supply_good,
	input  wire logic       vcc_present,
	input  wire logic       vcc_midband,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	input  wire logic       tx_header,
	input  wire logic       write_pause,
	input  wire logic       pause_tamper,
	input  wire logic       mem_req,
	input  wire logic       other_req,
	output logic            mod_on,
	output logic            tx_busy,
	output logic            rx_active,
	output logic            rx_bit,
	output logic            rx_bit_valid,
	output logic            rx_done,
	output logic            rx_error,
	output logic            retransmit,
	output logic            pause_done,
	output logic            mem_grant,
	output logic            mem_abort,
	output logic            cmd_grant
);
	typedef rfid_modem_pkg::cnt_t cnt_t;

	// Stage one feeds stage two only; stage three is for edge finding
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic [2:0] sync3;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
			sync3 <= 3'h0;
		end else if (clk_en) begin
			sync1 <= {coil_carrier, demod_level, vcc_present,
				supply_good, vcc_midband};
			sync2 <= sync1;
			sync3 <= sync2[4:2];
		end
	end

	wire car_tick = clk_en & sync2[4] & ~sync3[2];
	wire rx_lvl = ~sync2[3];
	wire rx_edge = clk_en & (sync2[3] ^ sync3[1]);
	wire vcc_drop = clk_en & sync3[0] & ~sync2[2];
	wire lrst_n = rst_n & ~vcc_drop;

	rfid_modem_pkg::mode_e mode;
	rfid_modem_pkg::mode_e next_mode;
	rfid_modem_pkg::gen_e  gen;

	logic [rfid_modem_pkg::WORD_W-1:0] replay_mem [rfid_modem_pkg::REPLAY_DEPTH];
	logic [rfid_modem_pkg::REPLAY_AW:0]   rec_cnt;
	logic [rfid_modem_pkg::REPLAY_AW-1:0] rd_idx;
	logic       replaying;
	logic [7:0] tx_byte;
	logic       word_last;
	logic [2:0] idx;
	logic       par;
	logic       cur_bit;
	logic       nxt_bit;
	logic       nxt_ok;
	cnt_t       tx_sub;
	cnt_t       listen_cnt;
	cnt_t       rx_sub;
	cnt_t       mid_ref;
	logic [1:0] bit_no;
	logic       saw_mid;
	logic       mid_dir;
	cnt_t       pause_cnt;
	cnt_t       pause_lim;

	wire [rfid_modem_pkg::WORD_W-1:0] buf_data;
	wire buf_valid;
	wire buf_ready;

	word_buffer #(
		.WIDTH (rfid_modem_pkg::WORD_W),
		.DEPTH (rfid_modem_pkg::BUF_DEPTH)
	) u_buf (
		.clk       (clk),
		.rst_n     (lrst_n),
		.clk_en    (clk_en),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   ({tx_header, tx_last, tx_data}),
		.out_valid (buf_valid),
		.out_ready (buf_ready),
		.out_data  (buf_data)
	);

	// Transmit timing and word fetch decode
	wire tx_mid = car_tick & (mode == rfid_modem_pkg::M_TX) &
		(tx_sub == rfid_modem_pkg::OUT_HALF_CYC - 1'b1);
	wire tx_end = car_tick & (mode == rfid_modem_pkg::M_TX) &
		(tx_sub == rfid_modem_pkg::OUT_BIT_CYC - 1'b1);
	wire step = tx_end & nxt_ok;
	wire can_start = (mode == rfid_modem_pkg::M_IDLE) |
		(mode == rfid_modem_pkg::M_LISTEN);
	wire start_new = clk_en & can_start & buf_valid;
	wire listen_out = car_tick & (mode == rfid_modem_pkg::M_LISTEN) &
		(listen_cnt == rfid_modem_pkg::RETX_CYC - 1'b1);
	wire start_replay = listen_out & ~buf_valid & (rec_cnt != '0);
	wire src_valid = replaying ?
		({1'b0, rd_idx} != rec_cnt) : buf_valid;
	wire fetch_more = step & (gen == rfid_modem_pkg::G_PAR) &
		~word_last & src_valid;
	wire from_mem = start_replay | (fetch_more & replaying);
	wire [rfid_modem_pkg::REPLAY_AW-1:0] fetch_idx =
		start_replay ? '0 : rd_idx;
	wire [rfid_modem_pkg::WORD_W-1:0] fetch_word =
		from_mem ? replay_mem[fetch_idx] : buf_data;
	wire start_tx = start_new | start_replay;
	assign buf_ready = start_new | (fetch_more & ~replaying);
	wire record = buf_ready & buf_valid & (start_new |
		(rec_cnt != (rfid_modem_pkg::REPLAY_AW+1)'(rfid_modem_pkg::REPLAY_DEPTH)));
	wire [rfid_modem_pkg::REPLAY_AW-1:0] rec_idx =
		start_new ? '0 : rec_cnt[rfid_modem_pkg::REPLAY_AW-1:0];
	wire fetch_hdr = fetch_word[rfid_modem_pkg::W_HDR];

	wire gen_bit = (gen == rfid_modem_pkg::G_PAR) ? par :
		(gen == rfid_modem_pkg::G_DATA) | (gen == rfid_modem_pkg::G_HDR) ?
		tx_byte[idx] : 1'b0;

	// Receive decode; the listen window also hides the first half bit
	// blind early listen
	wire lead_edge = rx_edge & (mode == rfid_modem_pkg::M_LISTEN) &
		(listen_cnt >= rfid_modem_pkg::LEAD_MIN_CYC) &
		(listen_cnt < rfid_modem_pkg::LEAD_MAX_CYC);
	wire in_leadin = (bit_no != rfid_modem_pkg::LEADIN_BITS);
	wire lead_win = (rx_sub >= rfid_modem_pkg::OFF_MIN_CYC) &
		(rx_sub <= rfid_modem_pkg::OFF_MAX_CYC);
	wire track_win = (rx_sub + rfid_modem_pkg::TRACK_TOL_CYC >= mid_ref) &
		(rx_sub <= mid_ref + rfid_modem_pkg::TRACK_TOL_CYC);
	wire mid_take = rx_edge & (mode == rfid_modem_pkg::M_RX) & ~saw_mid &
		(in_leadin ? (bit_no != rfid_modem_pkg::LEADIN_GAP_BIT) & lead_win
		: track_win);
	wire rx_end = car_tick & (mode == rfid_modem_pkg::M_RX) &
		(rx_sub == rfid_modem_pkg::IN_BIT_CYC - 1'b1);
	wire rx_stop = rx_end & ~saw_mid &
		(bit_no != rfid_modem_pkg::LEADIN_GAP_BIT);
	wire pause_end = car_tick & (mode == rfid_modem_pkg::M_PAUSE) &
		(pause_cnt == pause_lim - 1'b1);
	wire pause_go = clk_en & write_pause & (mode == rfid_modem_pkg::M_IDLE);

	always_comb begin
		next_mode = mode;
		case (mode)
			rfid_modem_pkg::M_IDLE: begin
				if (pause_go)
					next_mode = rfid_modem_pkg::M_PAUSE;
				else if (start_tx)
					next_mode = rfid_modem_pkg::M_TX;
			end
			rfid_modem_pkg::M_TX: begin
				if (tx_end & ~nxt_ok)
					next_mode = rfid_modem_pkg::M_LISTEN;
			end
			rfid_modem_pkg::M_LISTEN: begin
				if (start_tx)
					next_mode = rfid_modem_pkg::M_TX;
				else if (lead_edge)
					next_mode = rfid_modem_pkg::M_RX;
				else if (listen_out)
					next_mode = rfid_modem_pkg::M_IDLE;
			end
			rfid_modem_pkg::M_RX: begin
				if (rx_stop)
					next_mode = rfid_modem_pkg::M_IDLE;
			end
			rfid_modem_pkg::M_PAUSE: begin
				if (pause_end)
					next_mode = rfid_modem_pkg::M_IDLE;
			end
			default: next_mode = rfid_modem_pkg::M_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!lrst_n)
			mode <= rfid_modem_pkg::M_IDLE;
		else if (clk_en)
			mode <= next_mode;
	end

	// Replay store keeps the first 16 words of the last transmitted group
	always_ff @(posedge clk) begin
		if (record)
			replay_mem[rec_idx] <= buf_data;
	end

	always_ff @(posedge clk) begin
		if (!lrst_n) begin
			rec_cnt <= '0;
			rd_idx <= '0;
			replaying <= 1'b0;
		end else begin
			if (record)
				rec_cnt <= start_new ? (rfid_modem_pkg::REPLAY_AW+1)'(1) :
					rec_cnt + 1'b1;
			if (start_replay)
				rd_idx <= (rfid_modem_pkg::REPLAY_AW)'(1);
			else if (fetch_more & replaying)
				rd_idx <= rd_idx + 1'b1;
			if (start_tx)
				replaying <= start_replay;
		end
	end

	// Bit generator, one bit ahead of the encoder
	always_ff @(posedge clk) begin
		if (!lrst_n) begin
			gen <= rfid_modem_pkg::G_END;
			tx_byte <= 8'h00;
			word_last <= 1'b0;
			idx <= 3'h0;
			par <= 1'b0;
			cur_bit <= 1'b0;
			nxt_bit <= 1'b0;
			nxt_ok <= 1'b0;
		end else if (start_tx) begin
			tx_byte <= fetch_word[7:0];
			word_last <= fetch_word[rfid_modem_pkg::W_LAST];
			nxt_ok <= 1'b1;
			par <= fetch_word[rfid_modem_pkg::BYTE_MSB];
			cur_bit <= fetch_hdr ?
				fetch_word[rfid_modem_pkg::HDR_MSB] : 1'b1;
			nxt_bit <= fetch_hdr ? fetch_word[rfid_modem_pkg::HDR_MSB-1] :
				fetch_word[rfid_modem_pkg::BYTE_MSB];
			gen <= fetch_hdr ? rfid_modem_pkg::G_HDR : rfid_modem_pkg::G_DATA;
			idx <= fetch_hdr ? rfid_modem_pkg::HDR_IDX_FIRST :
				rfid_modem_pkg::DATA_IDX_FIRST;
		end else if (step) begin
			cur_bit <= nxt_bit;
			nxt_bit <= gen_bit;
			nxt_ok <= (gen != rfid_modem_pkg::G_END);
			case (gen)
				rfid_modem_pkg::G_DATA: begin
					par <= par ^ gen_bit;
					if (idx == 3'h0)
						gen <= rfid_modem_pkg::G_PAR;
					idx <= idx - 1'b1;
				end
				rfid_modem_pkg::G_PAR: begin
					if (fetch_more) begin
						tx_byte <= fetch_word[7:0];
						word_last <= fetch_word[rfid_modem_pkg::W_LAST];
						par <= 1'b0;
						idx <= 3'h7;
						gen <= rfid_modem_pkg::G_DATA;
					end else begin
						gen <= rfid_modem_pkg::G_STOP;
					end
				end
				rfid_modem_pkg::G_HDR: begin
					if (idx == 3'h0)
						gen <= rfid_modem_pkg::G_END;
					idx <= idx - 1'b1;
				end
				default: gen <= rfid_modem_pkg::G_END;
			endcase
		end
	end

	// Miller encoder drives the resistor directly
	always_ff @(posedge clk) begin
		if (!lrst_n) begin
			mod_on <= 1'b0;
			tx_sub <= '0;
		end else if (start_tx) begin
			mod_on <= 1'b0;
			tx_sub <= '0;
		end else if (car_tick & (mode == rfid_modem_pkg::M_TX)) begin
			tx_sub <= tx_end ? '0 : tx_sub + 1'b1;
			if (tx_mid & cur_bit)
				mod_on <= ~mod_on;
			else if (tx_end & ~nxt_ok)
				mod_on <= 1'b0;
			else if (tx_end & ~cur_bit & ~nxt_bit)
				mod_on <= ~mod_on;
		end
	end

	always_ff @(posedge clk) begin
		if (!lrst_n) begin
			listen_cnt <= '0;
			pause_cnt <= '0;
			pause_lim <= rfid_modem_pkg::MEM_PAUSE_CYC;
		end else begin
			if (mode != rfid_modem_pkg::M_LISTEN)
				listen_cnt <= '0;
			else if (car_tick)
				listen_cnt <= listen_cnt + 1'b1;
			if (pause_go) begin
				pause_cnt <= '0;
				pause_lim <= pause_tamper ?
					rfid_modem_pkg::TAMPER_PAUSE_CYC :
					rfid_modem_pkg::MEM_PAUSE_CYC;
			end else if (car_tick)
				pause_cnt <= pause_cnt + 1'b1;
		end
	end

	// Manchester receiver
	always_ff @(posedge clk) begin
		if (!lrst_n) begin
			rx_sub <= '0;
			bit_no <= 2'h0;
			saw_mid <= 1'b0;
			mid_dir <= 1'b0;
			mid_ref <= '0;
		end else if (lead_edge) begin
			rx_sub <= '0;
			bit_no <= 2'h0;
			saw_mid <= 1'b0;
		end else begin
			if (rx_end) begin
				rx_sub <= '0;
				saw_mid <= 1'b0;
				if (in_leadin)
					bit_no <= bit_no + 1'b1;
			end else if (car_tick)
				rx_sub <= rx_sub + 1'b1;
			if (mid_take) begin
				saw_mid <= 1'b1;
				mid_dir <= rx_lvl;
				mid_ref <= rx_sub;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!lrst_n) begin
			rx_bit <= 1'b0;
			rx_bit_valid <= 1'b0;
			rx_done <= 1'b0;
			rx_error <= 1'b0;
			retransmit <= 1'b0;
			pause_done <= 1'b0;
			mem_grant <= 1'b0;
			mem_abort <= 1'b0;
			cmd_grant <= 1'b0;
		end else if (clk_en) begin
			rx_bit_valid <= rx_end & saw_mid & ~in_leadin;
			if (rx_end & saw_mid & ~in_leadin)
				rx_bit <= mid_dir;
			rx_done <= rx_stop & ~in_leadin;
			rx_error <= rx_stop & in_leadin;
			retransmit <= start_replay;
			pause_done <= pause_end;
			mem_grant <= mem_req & sync2[1] & ~sync2[0];
			mem_abort <= mem_req & ~(sync2[1] & ~sync2[0]);
			cmd_grant <= other_req;
		end
	end

	assign tx_busy = (mode == rfid_modem_pkg::M_TX);
	assign rx_active = (mode == rfid_modem_pkg::M_RX);

endmodule

// *** core/word_buffer.sv ***
// Purpose: Small valid/ready FIFO in front of the transmitter.
// Assumes: DEPTH is a power of two, at least two.
// Notes:   Output word comes straight from the storage flops.
`timescale 1ns/1ps
module word_buffer #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              push;
	wire              pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = clk_en & in_valid & in_ready;
	assign pop = clk_en & out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

endmodule

// *** test/reader_model.sv ***
// Purpose: Reader base station driving the coil of the tag modem.
// Assumes: Carrier runs without pause, since it also powers the tag.
// Notes:   demod_level high is full amplitude, the idle state.
`timescale 1ns/1ps
module reader_model (
	output logic      coil_carrier,
	output logic      demod_level,
	input  wire logic tx_busy
);
	initial begin
		coil_carrier = 1'b0;
		demod_level  = 1'b1;
		#37;
		forever #80 coil_carrier = ~coil_carrier;
	end

	task automatic cw(input int n);
		repeat (n) @(posedge coil_carrier);
	endtask

	task automatic send(input logic [15:0] bits, input int n);
		@(negedge tx_busy);
		cw(60);
		demod_level = 1'b0;
		cw(32);
		demod_level = 1'b1;
		// Third edge sits mid bit three; data starts at bit four
		cw(128);
		demod_level = 1'b0;
		cw(32);
		for (int i = n - 1; i >= 0; i--) begin
			demod_level = bits[i];
			cw(32);
			demod_level = ~bits[i];
			cw(32);
		end
		demod_level = 1'b1;
	endtask
endmodule

// *** test/rfid_modem_checker_properties.sv ***
// Purpose: Port-level timing checks for the tag bit modem.
// Assumes: clk_en held high, so clk counts follow carrier counts.
// Notes:   One carrier period is 20 clk cycles in the bench.
`timescale 1ns/1ps
module rfid_modem_checker (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic supply_good,
	input  wire logic vcc_midband,
	input  wire logic mem_req,
	input  wire logic other_req,
	input  wire logic mod_on,
	input  wire logic tx_busy,
	input  wire logic rx_active,
	input  wire logic rx_bit_valid,
	input  wire logic retransmit,
	input  wire logic mem_grant,
	input  wire logic mem_abort,
	input  wire logic cmd_grant
);
	int   bit_gap;
	int   mod_gap;
	logic mod_q;

	// Gaps start large so the first event after reset is not judged
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bit_gap <= 5000;
			mod_gap <= 5000;
			mod_q   <= 1'b0;
		end else begin
			bit_gap <= rx_bit_valid ? 1 : bit_gap + 1;
			mod_gap <= (mod_on != mod_q) ? 1 : mod_gap + 1;
			mod_q   <= mod_on;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_low_mem;
		(!supply_good)[*6] ##0 mem_req;
	endsequence
	sequence s_mid_mem;
		vcc_midband[*6] ##0 mem_req;
	endsequence

	property p_mem_low;
		s_low_mem |=> mem_abort && !mem_grant;
	endproperty
	property p_mem_mid;
		s_mid_mem |=> mem_abort && !mem_grant;
	endproperty
	property p_cmd;
		other_req |=> cmd_grant;
	endproperty
	property p_mod_busy;
		$rose(mod_on) |-> tx_busy;
	endproperty
	property p_quiet_rx;
		rx_active |-> !mod_on;
	endproperty
	property p_rx_rate;
		rx_bit_valid && bit_gap < 2000 |-> bit_gap inside {[1270:1290]};
	endproperty
	property p_mod_spacing;
		mod_on != mod_q |-> mod_gap >= 155;
	endproperty
	property p_retx;
		retransmit |-> ##[0:6] tx_busy;
	endproperty

	a_mem_low: assert property (p_mem_low)
		else $error("memory access granted at low coil supply");
	a_mem_mid: assert property (p_mem_mid)
		else $error("memory access granted in wired midband");
	a_cmd: assert property (p_cmd)
		else $error("low-power command not granted");
	a_mod_busy: assert property (p_mod_busy)
		else $error("modulation switched on outside transmit");
	a_quiet_rx: assert property (p_quiet_rx)
		else $error("modulation active while receiving");
	a_rx_rate: assert property (p_rx_rate)
		else $error("received bit spacing not 64 carriers");
	a_mod_spacing: assert property (p_mod_spacing)
		else $error("modulation change closer than half a bit");
	a_retx: assert property (p_retx)
		else $error("replay flagged without transmission");
endmodule

bind rfid_tag_bit_modem rfid_modem_checker u_checker (
	.clk, .rst_n, .supply_good, .vcc_midband, .mem_req, .other_req,
	.mod_on, .tx_busy, .rx_active, .rx_bit_valid, .retransmit,
	.mem_grant, .mem_abort, .cmd_grant
);

// *** test/rfid_tag_bit_modem_test.sv ***
// Purpose: Self-checking bench for the tag bit modem.
// Assumes: Reader model makes the carrier and the inbound levels.
// Notes:   A carrier period is 20 clk cycles; run stays near 70k cycles.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	checks++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end
module rfid_tag_bit_modem_test;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       supply_good = 1'b1;
	logic       vcc_present = 1'b1;
	logic       vcc_midband = 1'b0;
	logic       tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic       tx_last = 1'b0;
	logic       tx_header = 1'b0;
	logic       write_pause = 1'b0;
	logic       pause_tamper = 1'b0;
	logic       mem_req = 1'b0;
	logic       other_req = 1'b0;
	logic       coil_carrier, demod_level, tx_ready, mod_on, tx_busy;
	logic       rx_active, rx_bit, rx_bit_valid, rx_done, rx_error;
	logic       retransmit, pause_done, mem_grant, mem_abort, cmd_grant;
	int         fail_count = 0;
	int         checks = 0;
	int         cyc = 0;
	int         car = 0;
	int         t_rise;

	rfid_tag_bit_modem DUT (.clk, .rst_n, .clk_en(1'b1), .coil_carrier,
		.demod_level, .supply_good, .vcc_present, .vcc_midband, .tx_valid,
		.tx_ready, .tx_data, .tx_last, .tx_header, .write_pause,
		.pause_tamper, .mem_req, .other_req, .mod_on, .tx_busy, .rx_active,
		.rx_bit, .rx_bit_valid, .rx_done, .rx_error, .retransmit,
		.pause_done, .mem_grant, .mem_abort, .cmd_grant);
	reader_model reader (.coil_carrier, .demod_level, .tx_busy);

	always #4 clk = ~clk;
	always @(posedge coil_carrier) car++;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			conclude();
		end
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cw(input int n);
		repeat (n) @(posedge coil_carrier);
	endtask

	task automatic push(input logic [7:0] d, input logic last, input logic hdr);
		@(posedge clk);
		tx_valid  <= 1'b1;
		tx_data   <= d;
		tx_last   <= last;
		tx_header <= hdr;
		do @(posedge clk); while (tx_ready !== 1'b1);
		tx_valid  <= 1'b0;
	endtask

	// Start bit, bytes MSB first with even parity, then stop bit
	function automatic logic [31:0] grp(input logic [15:0] d, input int nb);
		logic [31:0] r;
		logic [7:0]  by;
		r = 32'h1;
		for (int k = nb; k > 0; k--) begin
			by = d[8*k-1 -: 8];
			r  = {r[22:0], by, ^by};
		end
		return {r[30:0], 1'b0};
	endfunction

	// Samples each half bit in its middle against a Miller model
	task automatic check_tx(input logic [31:0] bits, input int n);
		logic lvl;
		logic nb;
		lvl = 1'b0;
		while (tx_busy !== 1'b1) @(posedge clk);
		t_rise = cyc;
		for (int i = n - 1; i >= 0; i--) begin
			nb = (i > 0) ? bits[i-1] : 1'b1;
			cw(4);
			`CHK(mod_on, lvl)
			cw(8);
			lvl = lvl ^ bits[i];
			`CHK(mod_on, lvl)
			cw(4);
			lvl = lvl ^ (~bits[i] & ~nb);
		end
	endtask

	task automatic t_grants;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			supply_good <= k[0];
			vcc_midband <= k[1];
			repeat (8) @(posedge clk);
			mem_req   <= 1'b1;
			other_req <= 1'b1;
			@(posedge clk);
			mem_req   <= 1'b0;
			other_req <= 1'b0;
			#1;
			`CHK(mem_grant, k == 1)
			`CHK(mem_abort, k != 1)
			`CHK(cmd_grant, 1'b1)
		end
		@(posedge clk);
		supply_good <= 1'b1;
		vcc_midband <= 1'b0;
		$display("test grants done");
	endtask

	task automatic t_pause(input logic tamper, input int exp, input logic fill);
		int c0;
		@(posedge clk);
		write_pause  <= 1'b1;
		pause_tamper <= tamper;
		@(posedge clk);
		write_pause  <= 1'b0;
		c0 = car;
		if (fill) begin
			push(8'h5a, 1'b0, 1'b0);
			push(8'hc7, 1'b1, 1'b0);
			@(posedge clk);
			`CHK(tx_ready, 1'b0)
			repeat (200) @(posedge clk);
			`CHK(tx_busy, 1'b0)
		end
		do @(posedge clk); while (pause_done !== 1'b1);
		`CHK(car - c0 inside {[exp - 2:exp + 2]}, 1'b1)
		$display("test pause done");
	endtask

	task automatic t_group;
		int c0;
		check_tx(grp(16'h5ac7, 2), 20);
		while (tx_busy !== 1'b0) @(posedge clk);
		c0 = car;
		do @(posedge clk); while (retransmit !== 1'b1);
		`CHK(car - c0 inside {[205:210]}, 1'b1)
		check_tx(grp(16'h5ac7, 2), 20);
		$display("test group done");
	endtask

	// Repeated bits put extra edges on the bit boundaries
	task automatic t_rx;
		logic [5:0] pat;
		pat = 6'b110010;
		fork
			reader.send({10'h000, pat}, 6);
			for (int i = 5; i >= 0; i--) begin
				do @(posedge clk); while (rx_bit_valid !== 1'b1);
				`CHK(rx_bit, pat[i])
			end
		join
		do @(posedge clk); while (rx_done !== 1'b1);
		`CHK(rx_error, 1'b0)
		$display("test receive done");
	endtask

	task automatic t_loss;
		int c0;
		@(posedge clk);
		write_pause  <= 1'b1;
		pause_tamper <= 1'b0;
		@(posedge clk);
		write_pause  <= 1'b0;
		cw(50);
		@(posedge clk);
		vcc_present <= 1'b0;
		c0 = cyc;
		// Let the supply-loss reset act before the word goes in
		repeat (4) @(posedge clk);
		vcc_present <= 1'b1;
		push(8'h0b, 1'b1, 1'b1);
		check_tx(32'hb, 4);
		`CHK(t_rise - c0 < 100, 1'b1)
		$display("test supply loss done");
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_grants();
		t_pause(1'b0, int'(rfid_modem_pkg::MEM_PAUSE_CYC), 1'b1);
		t_group();
		t_rx();
		t_pause(1'b1, int'(rfid_modem_pkg::TAMPER_PAUSE_CYC), 1'b0);
		t_loss();
		conclude();
	end
endmodule
